// ==== hw/timebase_pkg.sv ====
// constants and field layout for the periodic timebase
//
// Overview of operation
// - rollover at selected tap sets pending flag
// - interrupt request only while irq enable set
// - writing one to acknowledge clears flag
// - acknowledge bit is write-only, reads zero
// - unprescaled taps divide 32768 down to 8
// - prescaled taps are 128 times larger
// - period equals ratio over reference frequency
// - prescale select comes from configuration input
// - timebase off holds chain cleared
// - off then on restarts chain from zero
// - reset clears irq enable
// - reset clears timebase on
// - tap select is read/write, picks stage
// - pending flag read-only, rollover or acknowledge
// - wait mode counts, register not accessible
// - stop mode runs only with oscillator kept
// - stop without oscillator: inactive, no access
// - setting on starts counting from zero
// - first flag at half period, then full
package timebase_pkg;

	// ==========================================================
	// register map
	localparam logic [11:0] CTRL_OFFSET    = 12'h000;
	localparam int          CTRL_WIDTH     = 8;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;

	// ==========================================================
	// control field positions
	localparam int          FLAG_BIT       = 7;
	localparam int          TAP_LSB        = 4;
	localparam int          TAP_W          = 3;
	localparam int          ACK_BIT        = 3;
	localparam int          IE_BIT         = 2;
	localparam int          ON_BIT         = 1;

	// ==========================================================
	// divider structure
	localparam int          CHAIN_STAGES   = 15;
	localparam int          PRESCALE_W     = 7;
	localparam logic [6:0]  PRESCALE_LAST  = 7'h7f;

endpackage

// ==== hw/timebase_divider.sv ====
// prescaler and fifteen-stage divider chain with tap rollover detect
`timescale 1ns/1ps
module timebase_divider
	import timebase_pkg::*;
#(
	parameter int STAGES = CHAIN_STAGES
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// control
	input  wire logic             run,
	input  wire logic             src_tick,
	input  wire logic             prescale_sel,
	input  wire logic [TAP_W-1:0] tap,
	// event
	output logic                  rollover
);

	// ==========================================================
	// tap decode
	// each code names the chain bit whose rise marks a period
	function automatic int tap_index(input logic [TAP_W-1:0] code);
		case (code)
			3'h0:    tap_index = 14;
			3'h1:    tap_index = 12;
			3'h2:    tap_index = 10;
			3'h3:    tap_index = 6;
			3'h4:    tap_index = 5;
			3'h5:    tap_index = 4;
			3'h6:    tap_index = 3;
			default: tap_index = 2;
		endcase
	endfunction

	logic [PRESCALE_W-1:0] pre_reg;
	logic [PRESCALE_W-1:0] pre_next;
	logic [STAGES-1:0]     chain_reg;
	logic [STAGES-1:0]     chain_next;
	logic                  roll_reg;
	wire                   pre_wrap;
	wire                   step;
	wire                   tap_rise;

	// ==========================================================
	// stepping
	assign pre_wrap   = (pre_reg == PRESCALE_LAST);
	assign step       = run & src_tick & (~prescale_sel | pre_wrap);
	assign pre_next   = run ? (src_tick ? pre_reg + 7'h01 : pre_reg) : '0;
	assign chain_next = run ? (step ? chain_reg + STAGES'(1'b1) : chain_reg) : '0;
	// bit k rises first after 2^k steps, then every 2^(k+1): half, then full period
	assign tap_rise   = step & chain_next[tap_index(tap)] & ~chain_reg[tap_index(tap)];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg   <= '0;
			chain_reg <= '0;
			roll_reg  <= 1'b0;
		end else begin
			pre_reg   <= pre_next;
			chain_reg <= chain_next;
			roll_reg  <= tap_rise;
		end
	end

	assign rollover = roll_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_chain_cleared_off: assert property (!run |=> chain_reg == '0)
		else $error("divider chain not cleared while off");
	a_no_step_no_roll: assert property (!step |=> !roll_reg)
		else $error("rollover without a chain step");

endmodule

// ==== hw/periodic_timebase.sv ====
// periodic timebase: apb control register, flag, request and low-power gating
`timescale 1ns/1ps
module periodic_timebase
	import timebase_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// apb slave
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// reference clock pin, sampled
	input  wire logic              crystal_reference_clock,
	// configuration and power mode
	input  wire logic              source_prescale_select,
	input  wire logic              osc_run_in_stop,
	input  wire logic              wait_mode,
	input  wire logic              stop_mode,
	// interrupt request to the cpu
	output logic                   rollover_irq
);

	// ==========================================================
	// reference clock synchroniser
	// the reference is treated as a slow pin: it must stay well under
	// half of pclk or edges are missed
	logic       xtal_meta_reg;
	logic       xtal_sync_reg;
	logic       xtal_last_reg;
	wire        xtal_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_meta_reg <= 1'b0;
			xtal_sync_reg <= 1'b0;
			xtal_last_reg <= 1'b0;
		end else begin
			xtal_meta_reg <= crystal_reference_clock;
			xtal_sync_reg <= xtal_meta_reg;
			xtal_last_reg <= xtal_sync_reg;
		end
	end

	assign xtal_rise = xtal_sync_reg & ~xtal_last_reg;

	// ==========================================================
	// control state
	logic [TAP_W-1:0] tap_select_reg;
	logic             rollover_irq_enable_reg;
	logic             timebase_on_reg;
	logic             rollover_pending_flag_reg;
	logic             flag_next;
	logic             irq_reg;
	logic             rollover;

	// ==========================================================
	// apb decode
	// accesses in wait or stop are refused with pslverr and no effect
	wire        bus_blocked;
	wire        addr_hit;
	wire        setup;
	wire        access;
	wire        wr_ok;
	wire        ack_write;
	wire [7:0]  ctrl_view;
	wire [31:0] rd_word;
	logic       ready_reg;
	logic       err_reg;
	logic [31:0] rdata_reg;

	assign bus_blocked = wait_mode | stop_mode;
	assign addr_hit    = (paddr == ADDR_W'(CTRL_OFFSET));
	assign setup       = psel & ~penable;
	assign access      = psel & penable & ready_reg;
	assign wr_ok       = access & pwrite & addr_hit & ~err_reg;
	assign ack_write   = wr_ok & pwdata[ACK_BIT];

	// acknowledge bit and bit 0 always read zero
	assign ctrl_view = {rollover_pending_flag_reg, tap_select_reg, 1'b0,
		rollover_irq_enable_reg, timebase_on_reg, 1'b0};
	assign rd_word   = (addr_hit && !bus_blocked) ? {24'h000000, ctrl_view} : 32'h00000000;

	// zero wait state: ready rises in the access phase straight from setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_reg <= 1'b0;
			err_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ready_reg <= setup;
			err_reg   <= setup & (~addr_hit | bus_blocked);
			if (setup) begin
				rdata_reg <= rd_word;
			end
		end
	end

	assign pready  = ready_reg;
	assign pslverr = err_reg;
	assign prdata  = rdata_reg;

	// ==========================================================
	// control register writes
	// tap changes while running are taken as written; the chain may
	// then skip or double one period, which software is told to avoid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_select_reg          <= CTRL_RESET[TAP_LSB +: TAP_W];
			rollover_irq_enable_reg <= CTRL_RESET[IE_BIT];
			timebase_on_reg         <= CTRL_RESET[ON_BIT];
		end else if (wr_ok) begin
			tap_select_reg          <= pwdata[TAP_LSB +: TAP_W];
			rollover_irq_enable_reg <= pwdata[IE_BIT];
			timebase_on_reg         <= pwdata[ON_BIT];
		end
	end

	// ==========================================================
	// divider
	// in stop the reference only runs when the oscillator is kept alive
	wire run;
	wire src_tick;

	assign run      = timebase_on_reg;
	assign src_tick = xtal_rise & (~stop_mode | osc_run_in_stop);

	timebase_divider #(
		.STAGES(CHAIN_STAGES)
	) u_divider (
		.pclk        (pclk),
		.presetn     (presetn),
		.run         (run),
		.src_tick    (src_tick),
		.prescale_sel(source_prescale_select),
		.tap         (tap_select_reg),
		.rollover    (rollover)
	);

	// ==========================================================
	// flag and request
	// a rollover in the acknowledge cycle keeps the flag set
	assign flag_next = rollover | (rollover_pending_flag_reg & ~ack_write);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rollover_pending_flag_reg <= CTRL_RESET[FLAG_BIT];
			irq_reg                   <= 1'b0;
		end else begin
			rollover_pending_flag_reg <= flag_next;
			irq_reg                   <= flag_next & rollover_irq_enable_reg;
		end
	end

	assign rollover_irq = irq_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence ack_only_s;
		ack_write && !rollover;
	endsequence

	sequence flag_clear_s;
		!rollover_pending_flag_reg;
	endsequence

	a_flag_set_roll: assert property (rollover |=> rollover_pending_flag_reg)
		else $error("rollover did not set the pending flag");

	a_ack_clears_flag: assert property (ack_only_s |=> flag_clear_s)
		else $error("acknowledge write did not clear the flag");

	a_flag_rise_cause: assert property ($rose(rollover_pending_flag_reg) |-> $past(rollover))
		else $error("flag set without a rollover");

	a_flag_fall_cause: assert property ($fell(rollover_pending_flag_reg) |-> $past(ack_write))
		else $error("flag cleared without an acknowledge write");

	a_irq_gated_off: assert property (!rollover_irq_enable_reg |=> !rollover_irq)
		else $error("request raised with enable clear");

	a_irq_follows_flag: assert property (
		rollover_pending_flag_reg && rollover_irq_enable_reg && !ack_write |=> rollover_irq)
		else $error("pending enabled flag gave no request");

	a_ack_reads_zero: assert property (setup |=> prdata[ACK_BIT] == 1'b0)
		else $error("acknowledge bit read as one");

	a_off_no_roll: assert property (!timebase_on_reg [*2] |-> !rollover)
		else $error("rollover while timebase off");

	a_blocked_no_write: assert property (
		setup && bus_blocked ##1 access |=> $stable(tap_select_reg) && $stable(timebase_on_reg))
		else $error("register written in a low-power mode");

	a_stop_no_count: assert property (stop_mode && !osc_run_in_stop |-> !src_tick)
		else $error("reference ticks in stop without oscillator");

	a_apb_ready: assert property (setup |=> pready ##1 !pready)
		else $error("apb answer not in the access phase");

endmodule

// ==== tb/periodic_timebase_test.sv ====
// self-checking apb bench for the periodic timebase
`timescale 1ns/1ps
module periodic_timebase_test;
	import timebase_pkg::*;
	// ==========================================================
	// bench signals
	logic        pclk                   = 1'b0;
	logic        presetn                = 1'b0;
	logic        psel                   = 1'b0;
	logic        penable                = 1'b0;
	logic        pwrite                 = 1'b0;
	logic [11:0] paddr                  = 12'h000;
	logic [31:0] pwdata                 = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        source_prescale_select = 1'b0;
	logic        osc_run_in_stop        = 1'b0;
	logic        wait_mode              = 1'b0;
	logic        stop_mode              = 1'b0;
	logic        rollover_irq;
	logic [1:0]  ref_cnt                = 2'h0;
	logic [31:0] rdv;
	logic        erv;
	logic        ok;
	int          errors                 = 0;
	int          check_count            = 0;
	int          cyc                    = 0;
	int          first;
	int          per;
	int          ratio [8]              = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

	periodic_timebase i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.crystal_reference_clock(ref_cnt[1]),
		.source_prescale_select(source_prescale_select),
		.osc_run_in_stop(osc_run_in_stop), .wait_mode(wait_mode),
		.stop_mode(stop_mode), .rollover_irq(rollover_irq)
	);

	// ==========================================================
	// clocks and watchdog
	always #12.5 pclk = ~pclk;

	// reference runs at a quarter of pclk so every edge survives the synchroniser
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		ref_cnt <= ref_cnt + 2'h1;
		if (cyc == 60000) begin
			errors = errors + 1;
			report_and_stop();
		end
	end

	// ==========================================================
	// tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// one idle cycle at the end keeps back-to-back calls from double-driving psel
	// no cycle limit here: a slave that never answers is caught by the watchdog
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// waits up to 8 cycles for the request to drop, then up to lim cycles for it to be high
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (rollover_irq === 1'b1 && n < 8) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		while (rollover_irq !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		ok = (rollover_irq === 1'b1);
	endtask

	task automatic period(input logic [7:0] ctl);
		int t;
		apb(1'b1, CTRL_OFFSET, 8'h08);
		t = cyc;
		apb(1'b1, CTRL_OFFSET, ctl);
		wait_irq(20000);
		first = cyc - t;
		t = cyc;
		apb(1'b1, CTRL_OFFSET, ctl | 8'h08);
		wait_irq(20000);
		per = cyc - t;
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, CTRL_OFFSET, 8'h00);
		check("reset ctrl", rdv, 32'h0);
		check("reset irq", rollover_irq, 32'h0);
		apb(1'b1, CTRL_OFFSET, 8'hff);
		apb(1'b0, CTRL_OFFSET, 8'h00);
		check("ctrl readback", rdv, 32'h76);
		// codes 0 and 1 would blow the run budget
		for (int c = 2; c < 8; c++) begin
			period({1'b0, c[2:0], 4'h6});
			check("period", per, ratio[c] * 4);
			check("first", (first >= ratio[c] * 2 && first <= ratio[c] * 2 + 12), 1);
		end
		source_prescale_select <= 1'b1;
		period(8'h76);
		check("prescaled period", per, 32'd4096);
		apb(1'b1, CTRL_OFFSET, 8'h76);
		apb(1'b0, CTRL_OFFSET, 8'h00);
		check("ack zero", rdv, 32'hf6);
		check("irq on", rollover_irq, 32'h1);
		apb(1'b1, CTRL_OFFSET, 8'h7e);
		apb(1'b0, CTRL_OFFSET, 8'h00);
		check("ack one", rdv, 32'h76);
		apb(1'b1, CTRL_OFFSET, 8'h72);
		repeat (4300) @(posedge pclk);
		apb(1'b0, CTRL_OFFSET, 8'h00);
		check("flag masked", rdv, 32'hf2);
		check("irq masked", rollover_irq, 32'h0);
		apb(1'b1, CTRL_OFFSET, 8'h08);
		repeat (5000) @(posedge pclk);
		apb(1'b0, CTRL_OFFSET, 8'h00);
		check("off idle", rdv, 32'h0);
		apb(1'b1, 12'h004, 8'h06);
		check("unmapped write err", erv, 32'h1);
		apb(1'b0, 12'h004, 8'h00);
		check("unmapped read", {rdv[31:1], erv}, 32'h1);
		source_prescale_select <= 1'b0;
		apb(1'b1, CTRL_OFFSET, 8'h76);
		wait_mode <= 1'b1;
		apb(1'b0, CTRL_OFFSET, 8'h00);
		check("wait read", {rdv[31:1], erv}, 32'h1);
		wait_irq(200);
		check("wait counts", ok, 32'h1);
		wait_mode <= 1'b0;
		apb(1'b1, CTRL_OFFSET, 8'h7e);
		wait_irq(200);
		apb(1'b1, CTRL_OFFSET, 8'h7e);
		stop_mode <= 1'b1;
		apb(1'b0, CTRL_OFFSET, 8'h00);
		check("stop read", {rdv[31:1], erv}, 32'h1);
		wait_irq(200);
		check("stop idle", ok, 32'h0);
		osc_run_in_stop <= 1'b1;
		wait_irq(200);
		check("stop wake", ok, 32'h1);
		stop_mode <= 1'b0;
		osc_run_in_stop <= 1'b0;
		report_and_stop();
	end
endmodule
